// ==== pioc_config_bank.sv ====
// What this block does
// - rx frame-marker select: 0 puts data-enable on shared pin, 1 start-of-frame.
// - tx clock output select: 0 gapped clock, 1 plain output clock.
// - tx frame-marker select: 0 puts data-enable on shared pin, 1 start-of-frame.
// - port 8 kHz reference from rx framer clock (0) or tx framer clock (1).
// - trailer and one-second timer use global (0) or this port's (1) reference.
// - loop time clocks transmit from receive side, or rate adapter when allowed and tx clock idle; never the tx input clock pin.
// - rate-adapter control: 0 allows adapter clocks, 1 forces input pin unless looped.
// - rx framer pins timed by output clocks (0) or input clocks (1).
// - tx framer pins timed by output clocks (0) or input clocks (1).
// - tx line pins timed by output clocks (0) or input clocks (1).
// - three-bit loopback field picks analog, line, payload, diagnostic; reset means none.
// - four-bit field picks alarm on second pin; software enables pin elsewhere.
// - four-bit field picks alarm on first pin; software enables pin elsewhere.
// - each set tx invert bit flips its transmit pin; clear leaves it.
// - each set rx invert bit flips its receive pin; clear leaves it.
// - summary bit set while sub-block has enabled latched status; irq needs global enable.
`timescale 1ns/100ps
`default_nettype none

`include "pioc_regs.svh"

module pioc_config_bank #(
   parameter logic [2:0] LB_CODE_ANALOG = 3'h1, // loopback code table entry
   parameter logic [2:0] LB_CODE_LINE = 3'h2, // loopback code table entry
   parameter logic [2:0] LB_CODE_PAYLOAD = 3'h3, // loopback code table entry
   parameter logic [2:0] LB_CODE_DIAG = 3'h4 // loopback code table entry
) (
   input wire logic clk, // 10 MHz system clock
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   // host register port
   input wire logic busCs_n, // chip select, active low
   input wire logic busRd_n, // read strobe, active low
   input wire logic busWr_n, // write strobe, active low
   input wire logic [7:0] busAddr, // port-local byte address
   input wire logic [15:0] busWdata, // write data
   output logic [15:0] busRdata, // registered read data
   // shared frame-marker and clock sources from the core
   input wire logic rxDataEnable, // rx data-enable, nominal polarity
   input wire logic rxSofOut, // rx start-of-frame, nominal polarity
   input wire logic rxGappedClk, // rx gapped clock
   input wire logic rxClkOut, // rx plain output clock
   input wire logic txDataEnable, // tx data-enable, nominal polarity
   input wire logic txSofOut, // tx start-of-frame, nominal polarity
   input wire logic txGappedClk, // tx gapped clock
   input wire logic txClkOut, // tx plain output clock
   // transmit pins, bit positions follow the tx invert register
   input wire logic [15:0] txCoreOut, // core-driven tx pins, nominal
   input wire logic [15:0] txPinIn, // tx input pins as seen on the package
   output logic [15:0] txPinOut, // tx output pins toward the package
   output logic [15:0] txCoreIn, // tx input pins in nominal polarity
   // receive pins, bit positions follow the rx invert register
   input wire logic [15:0] rxCoreOut, // core-driven rx pins, nominal
   input wire logic [15:0] rxPinIn, // rx input pins as seen on the package
   output logic [15:0] rxPinOut, // rx output pins toward the package
   output logic [15:0] rxCoreIn, // rx input pins in nominal polarity
   // 8 kHz references
   input wire logic rxFramerRef, // 8 kHz tick from rx framer clock
   input wire logic txFramerRef, // 8 kHz tick from tx framer clock
   input wire logic globalRef, // global 8 kHz tick
   output pioc_pkg::pioc_ref_type refOut, // port reference and timer reference
   // transmit clock choice
   input wire logic txClkInActive, // tx input clock pin shows activity
   output pioc_pkg::pioc_txclk_src_type txClkSrc, // selected tx clock source
   output pioc_pkg::pioc_timing_type pinTiming, // timing references for pins
   output pioc_pkg::pioc_loopback_type loopback, // decoded loopback request
   // alarm routing
   input wire logic [15:0] alarmStatus, // alarm signals by select code
   output logic alarmPinFirst, // alarm for first general-purpose pin
   output logic alarmPinSecond, // alarm for second general-purpose pin
   // interrupt summary
   input wire logic [6:0] subBlockIrq, // enabled latched status per sub-block
   input wire logic globalPortIrqEnable, // global per-port interrupt enable
   output logic portIrq // interrupt request toward the pin
);
   import pioc_pkg::*;

   // ==========================================
   // register storage
   logic [15:0] ctrlThree_r;
   logic [15:0] ctrlFour_r;
   logic [15:0] txInvert_r;
   logic [15:0] rxInvert_r;
   logic [15:0] irqSummary_r;
   logic [15:0] rdata_nxt;
   logic [15:0] irqSummary_nxt;
   logic [15:0] txMuxed;
   logic [15:0] rxMuxed;
   logic wrEn;
   logic rdEn;
   logic wrThreeHit;
   logic wrFourHit;
   logic wrTxInvHit;
   logic wrRxInvHit;
   logic portRefSel;
   logic anyLoopback;

   assign wrEn = ce & ~busCs_n & ~busWr_n;
   assign rdEn = ce & ~busCs_n & ~busRd_n;

   // one strobe per writable register, exact address match only
   assign wrThreeHit = wrEn && (busAddr == `PIOC_OFS_CTRL_THREE);
   assign wrFourHit = wrEn && (busAddr == `PIOC_OFS_CTRL_FOUR);
   assign wrTxInvHit = wrEn && (busAddr == `PIOC_OFS_TX_INV);
   assign wrRxInvHit = wrEn && (busAddr == `PIOC_OFS_RX_INV);

   // ==========================================
   // host writes
   // control three
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlThree_r <= `PIOC_RST_CTRL_THREE;
      end else if (wrThreeHit) begin
         ctrlThree_r <= busWdata & `PIOC_MASK_CTRL_THREE;
      end
   end

   // control four, reset leaves loopback at none
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlFour_r <= `PIOC_RST_CTRL_FOUR;
      end else if (wrFourHit) begin
         ctrlFour_r <= busWdata & `PIOC_MASK_CTRL_FOUR;
      end
   end

   // tx invert mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txInvert_r <= `PIOC_RST_TX_INV;
      end else if (wrTxInvHit) begin
         txInvert_r <= busWdata & `PIOC_MASK_TX_INV;
      end
   end

   // rx invert mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxInvert_r <= `PIOC_RST_RX_INV;
      end else if (wrRxInvHit) begin
         rxInvert_r <= busWdata & `PIOC_MASK_RX_INV;
      end
   end

   // ==========================================
   // interrupt summary
   // summary follows sub-block levels, it is not sticky here
   always_comb begin
      irqSummary_nxt = 16'h0000;
      irqSummary_nxt[9:4] = subBlockIrq[6:1];
      irqSummary_nxt[0] = subBlockIrq[0];
   end

   // summary register, reserved bits held at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqSummary_r <= 16'h0000;
      end else if (ce) begin
         irqSummary_r <= irqSummary_nxt & `PIOC_MASK_IRQ_SUM;
      end
   end

   // request only with the global per-port enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         portIrq <= 1'b0;
      end else if (ce) begin
         portIrq <= (|irqSummary_nxt) & globalPortIrqEnable;
      end
   end

   // ==========================================
   // host reads, unmapped addresses return zero
   always_comb begin
      case (busAddr)
         `PIOC_OFS_CTRL_THREE: rdata_nxt = ctrlThree_r;
         `PIOC_OFS_CTRL_FOUR: rdata_nxt = ctrlFour_r;
         `PIOC_OFS_TX_INV: rdata_nxt = txInvert_r;
         `PIOC_OFS_RX_INV: rdata_nxt = rxInvert_r;
         `PIOC_OFS_IRQ_SUM: rdata_nxt = irqSummary_r;
         default: rdata_nxt = 16'h0000;
      endcase
   end

   // read data held until the next read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busRdata <= 16'h0000;
      end else if (rdEn) begin
         busRdata <= rdata_nxt;
      end
   end

   // ==========================================
   // loopback decode from the code table
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loopback <= '0;
      end else if (ce) begin
         loopback <= '0; // unknown codes mean no loopback
         case (ctrlFour_r[`PIOC_LOOPBACK_MSB:`PIOC_LOOPBACK_LSB])
            LB_CODE_ANALOG: loopback.analogLoop <= 1'b1;
            LB_CODE_LINE: loopback.lineLoop <= 1'b1;
            LB_CODE_PAYLOAD: loopback.payloadLoop <= 1'b1;
            LB_CODE_DIAG: loopback.diagnosticLoop <= 1'b1;
            default: loopback <= '0;
         endcase
      end
   end

   // any decoded loopback, steers the tx clock choice
   assign anyLoopback = |loopback;

   // ==========================================
   // alarm routing to general-purpose pins
   // pin output enable is owned by the global pin control
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alarmPinFirst <= 1'b0;
         alarmPinSecond <= 1'b0;
      end else if (ce) begin
         alarmPinFirst <= alarmStatus[ctrlFour_r[`PIOC_ALARM_FIRST_MSB:`PIOC_ALARM_FIRST_LSB]];
         alarmPinSecond <= alarmStatus[ctrlFour_r[`PIOC_ALARM_SECOND_MSB:`PIOC_ALARM_SECOND_LSB]];
      end
   end

   // ==========================================
   // 8 kHz reference routing
   // selected port source, shared by the port and timer outputs
   assign portRefSel = ctrlThree_r[`PIOC_BIT_PORT_REF_SRC] ? txFramerRef : rxFramerRef;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refOut <= '0;
      end else if (ce) begin
         refOut.portRef <= portRefSel;
         refOut.timerRef <= ctrlThree_r[`PIOC_BIT_PORT_REF_USAGE] ? portRefSel
                                                                   : globalRef;
      end
   end

   // ==========================================
   // transmit clock source
   // loop time wins; the input pin is never used then
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txClkSrc <= TXCLK_PIN;
      end else if (ce) begin
         if (ctrlThree_r[`PIOC_BIT_LOOP_TIME]) begin
            if (!ctrlThree_r[`PIOC_BIT_RATE_ADAPTER_CTL] && !txClkInActive) begin
               txClkSrc <= TXCLK_RATE_ADAPTER;
            end else begin
               txClkSrc <= TXCLK_RX_LINE;
            end
         end else if (ctrlThree_r[`PIOC_BIT_RATE_ADAPTER_CTL]) begin
            // adapter excluded: input pin unless a loopback is active
            if (anyLoopback) begin
               txClkSrc <= TXCLK_RX_LINE;
            end else begin
               txClkSrc <= TXCLK_PIN;
            end
         end else if (!txClkInActive) begin
            txClkSrc <= TXCLK_RATE_ADAPTER;
         end else begin
            txClkSrc <= TXCLK_PIN;
         end
      end
   end

   // ==========================================
   // pin timing references
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinTiming <= '0;
      end else if (ce) begin
         pinTiming.rxFramerInputTiming <= ctrlThree_r[`PIOC_BIT_RX_FRAMER_TIMING];
         pinTiming.txFramerInputTiming <= ctrlThree_r[`PIOC_BIT_TX_FRAMER_TIMING];
         pinTiming.txLineInputTiming <= ctrlThree_r[`PIOC_BIT_TX_LINE_TIMING];
      end
   end

   // ==========================================
   // shared pin function selection, nominal polarity
   always_comb begin
      txMuxed = txCoreOut;
      txMuxed[`PIOC_TX_PIN_SOF_OUT] = ctrlThree_r[`PIOC_BIT_TX_FRAME_MARKER_SEL]
                                      ? txSofOut : txDataEnable;
      txMuxed[`PIOC_TX_PIN_CLK_OUT] = ctrlThree_r[`PIOC_BIT_TX_CLK_OUT_SEL]
                                      ? txClkOut : txGappedClk;
   end

   // rx clock output select follows the same pattern as tx
   always_comb begin
      rxMuxed = rxCoreOut;
      rxMuxed[`PIOC_RX_PIN_SOF_OUT] = ctrlThree_r[`PIOC_BIT_RX_FRAME_MARKER_SEL]
                                      ? rxSofOut : rxDataEnable;
      rxMuxed[`PIOC_RX_PIN_CLK_OUT] = ctrlThree_r[`PIOC_BIT_RX_CLK_OUT_SEL]
                                      ? rxClkOut : rxGappedClk;
   end

   // ==========================================
   // polarity inversion, only between core and package
   // tx outputs toward the package
   pioc_pin_inv #(
      .W(16)
   ) uTxOutInv (
      .pinIn(txMuxed),
      .invert(txInvert_r),
      .implemented(`PIOC_MASK_TX_INV),
      .pinOut(txPinOut)
   );

   // tx inputs back to nominal
   pioc_pin_inv #(
      .W(16)
   ) uTxInInv (
      .pinIn(txPinIn),
      .invert(txInvert_r),
      .implemented(`PIOC_MASK_TX_INV),
      .pinOut(txCoreIn)
   );

   // rx outputs toward the package
   pioc_pin_inv #(
      .W(16)
   ) uRxOutInv (
      .pinIn(rxMuxed),
      .invert(rxInvert_r),
      .implemented(`PIOC_MASK_RX_INV),
      .pinOut(rxPinOut)
   );

   // rx inputs back to nominal
   pioc_pin_inv #(
      .W(16)
   ) uRxInInv (
      .pinIn(rxPinIn),
      .invert(rxInvert_r),
      .implemented(`PIOC_MASK_RX_INV),
      .pinOut(rxCoreIn)
   );

endmodule

`default_nettype wire

// ==== pioc_config_bank_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// port checker of the configuration bank
module pioc_config_bank_assertions (
   input wire logic clk, // system clock
   input wire logic rst_n, // reset, active low
   input wire logic ce, // clock enable
   input wire logic busCs_n, // select, active low
   input wire logic busRd_n, // read, active low
   input wire logic busWr_n, // write, active low
   input wire logic [7:0] busAddr, // byte address
   input wire logic [15:0] busWdata, // write data
   input wire logic [15:0] busRdata, // read data
   input wire logic [15:0] txCoreOut, // core tx pins
   input wire logic [15:0] txPinIn, // package tx inputs
   input wire logic [15:0] txPinOut, // package tx outputs
   input wire logic [15:0] txCoreIn, // nominal tx inputs
   input wire logic txClkInActive, // tx input clock activity
   input wire pioc_pkg::pioc_txclk_src_type txClkSrc, // tx clock source
   input wire pioc_pkg::pioc_timing_type pinTiming, // pin timing
   input wire pioc_pkg::pioc_loopback_type loopback, // loopback request
   input wire logic [6:0] subBlockIrq, // sub-block requests
   input wire logic globalPortIrqEnable, // global enable
   input wire logic portIrq // interrupt request
);
   import pioc_pkg::*;
   logic rdHit, wrCtrl3, wrTxInv, mapped, irqReq;
   logic [2:0] wTiming;
   logic [15:0] txInvSeen, txOutInv;
   // decoded bus cycles and seen inversion
   assign rdHit = ce && !busCs_n && !busRd_n;
   assign wrCtrl3 = ce && !busCs_n && !busWr_n && busAddr == 8'h44;
   assign wrTxInv = ce && !busCs_n && !busWr_n && busAddr == 8'h4A;
   assign mapped = busAddr inside {8'h44, 8'h46, 8'h4A, 8'h4C, 8'h50};
   assign irqReq = |subBlockIrq && globalPortIrqEnable;
   assign wTiming = busWdata[2:0];
   assign txInvSeen = (txCoreIn ^ txPinIn) & 16'h17FF;
   assign txOutInv = (txPinOut ^ txCoreOut) & 16'h07FD;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ==========================================
   // assertions
   AST_IRQ_FOLLOW: assert property (ce |=> portIrq == $past(irqReq))
      else $error("portIrq does not follow the enabled requests");
   AST_UNMAPPED_READ: assert property (rdHit && !mapped |=> busRdata == 16'h0000)
      else $error("unmapped read returned nonzero data");
   AST_RDATA_HOLD: assert property (!rdHit |=> $stable(busRdata))
      else $error("read data changed without a read");
   AST_TX_PAIR: assert property (txOutInv == (txInvSeen & 16'h07FD))
      else $error("tx output and input inversion disagree");
   AST_TX_INV_HOLD: assert property (!wrTxInv |=> $stable(txInvSeen))
      else $error("tx inversion changed without a write");
   AST_TIMING_VALUE: assert property (wrCtrl3 ##1 ce |=> pinTiming == $past(wTiming, 2))
      else $error("pin timing does not match written bits");
   AST_LOOPBACK_ONEHOT: assert property ($onehot0(loopback))
      else $error("more than one loopback requested");
   AST_TXCLK_LEGAL: assert property (ce |=> txClkSrc != 2'b11
      && (txClkSrc != TXCLK_RATE_ADAPTER || !$past(txClkInActive)))
      else $error("tx clock source out of range or adapter chosen with live input clock");

   // main scenarios reached
   cover property (wrCtrl3 ##2 pinTiming != 3'b000);
   cover property (irqReq ##1 portIrq);
   cover property (loopback.analogLoop);
endmodule

bind pioc_config_bank pioc_config_bank_assertions u_chk (.clk, .rst_n, .ce, .busCs_n,
   .busRd_n, .busWr_n, .busAddr, .busWdata, .busRdata, .txCoreOut, .txPinIn, .txPinOut,
   .txCoreIn, .txClkInActive, .txClkSrc, .pinTiming, .loopback, .subBlockIrq,
   .globalPortIrqEnable, .portIrq);

`default_nettype wire

// ==== pioc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// host processor on the parallel register port
module pioc_host_model (
   input wire logic clk, // bus clock
   output var logic busCs_n, // select, active low
   output var logic busRd_n, // read, active low
   output var logic busWr_n, // write, active low
   output var logic [7:0] busAddr, // byte address
   output var logic [15:0] busWdata, // write data
   input wire logic [15:0] busRdata // read data
);
   // idle bus at time zero
   initial begin
      busCs_n = 1'b1;
      busRd_n = 1'b1;
      busWr_n = 1'b1;
      busAddr = 8'h00;
      busWdata = 16'h0000;
   end

   // one write, held over its taking edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      busAddr = a;
      busWdata = d;
      busCs_n = 1'b0;
      busWr_n = 1'b0;
      @(posedge clk);
      #1;
      busCs_n = 1'b1;
      busWr_n = 1'b1;
      busAddr = ~a; // released lines lose the last value
      busWdata = ~d;
   endtask

   // one read, data sampled 1 ns after the taking edge
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      #1;
      busAddr = a;
      busCs_n = 1'b0;
      busRd_n = 1'b0;
      @(posedge clk);
      #1;
      d = busRdata;
      busCs_n = 1'b1;
      busRd_n = 1'b1;
      busAddr = ~a;
   endtask
endmodule

`default_nettype wire

// ==== pioc_pin_inv.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// polarity inversion at the pin boundary
module pioc_pin_inv #(
   parameter int W = 16
) (
   input wire logic [W-1:0] pinIn, // nominal or pin-side level
   input wire logic [W-1:0] invert, // per-pin invert mask
   input wire logic [W-1:0] implemented, // bits that exist as pins
   output logic [W-1:0] pinOut // level after inversion
);

   // xor with the mask, absent pins held low
   assign pinOut = (pinIn ^ invert) & implemented;

endmodule

`default_nettype wire

// ==== pioc_pkg.sv ====
`default_nettype none

// ==========================================
// shared types of the port configuration bank
package pioc_pkg;

   // decoded loopback request, one bit per kind
   typedef struct packed {
      logic analogLoop;
      logic lineLoop;
      logic payloadLoop;
      logic diagnosticLoop;
   } pioc_loopback_type;

   // source of the internal transmit clock
   typedef enum logic [1:0] {
      TXCLK_PIN = 2'b00,
      TXCLK_RX_LINE = 2'b01,
      TXCLK_RATE_ADAPTER = 2'b10
   } pioc_txclk_src_type;

   // timing references of the framer and line pins, 1 = input clocks
   typedef struct packed {
      logic rxFramerInputTiming;
      logic txFramerInputTiming;
      logic txLineInputTiming;
   } pioc_timing_type;

   // 8 kHz reference routing
   typedef struct packed {
      logic portRef;
      logic timerRef;
   } pioc_ref_type;

endpackage

`default_nettype wire

// ==== pioc_regs.svh ====
`ifndef PIOC_REGS_SVH
`define PIOC_REGS_SVH

// ==========================================
// register offsets, port-local byte address
`define PIOC_OFS_CTRL_THREE 8'h44
`define PIOC_OFS_CTRL_FOUR 8'h46
`define PIOC_OFS_TX_INV 8'h4A
`define PIOC_OFS_RX_INV 8'h4C
`define PIOC_OFS_IRQ_SUM 8'h50

// ==========================================
// reset values
`define PIOC_RST_CTRL_THREE 16'h0000
`define PIOC_RST_CTRL_FOUR 16'h0000
`define PIOC_RST_TX_INV 16'h0000
`define PIOC_RST_RX_INV 16'h0000

// ==========================================
// implemented bits, the rest read as zero
`define PIOC_MASK_CTRL_THREE 16'h36FF
`define PIOC_MASK_CTRL_FOUR 16'h07FF
`define PIOC_MASK_TX_INV 16'h17FF
`define PIOC_MASK_RX_INV 16'h16DE
`define PIOC_MASK_IRQ_SUM 16'h03F1

// ==========================================
// control three field positions
`define PIOC_BIT_RX_CLK_OUT_SEL 13
`define PIOC_BIT_RX_FRAME_MARKER_SEL 12
`define PIOC_BIT_TX_CLK_OUT_SEL 10
`define PIOC_BIT_TX_FRAME_MARKER_SEL 9
`define PIOC_BIT_PORT_REF_SRC 6
`define PIOC_BIT_PORT_REF_USAGE 5
`define PIOC_BIT_LOOP_TIME 4
`define PIOC_BIT_RATE_ADAPTER_CTL 3
`define PIOC_BIT_RX_FRAMER_TIMING 2
`define PIOC_BIT_TX_FRAMER_TIMING 1
`define PIOC_BIT_TX_LINE_TIMING 0

// ==========================================
// control four field positions
`define PIOC_LOOPBACK_MSB 10
`define PIOC_LOOPBACK_LSB 8
`define PIOC_ALARM_SECOND_MSB 7
`define PIOC_ALARM_SECOND_LSB 4
`define PIOC_ALARM_FIRST_MSB 3
`define PIOC_ALARM_FIRST_LSB 0

// ==========================================
// pin positions shared by invert masks and pin vectors
`define PIOC_TX_PIN_SOF_OUT 12
`define PIOC_TX_PIN_CLK_OUT 1
`define PIOC_RX_PIN_SOF_OUT 12
`define PIOC_RX_PIN_CLK_OUT 1

`endif

// ==== port_io_config_bank_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
   $display("MISMATCH %s expected %h seen %h", nm, ex, gt); bad_count++; end end

// ==========================================
// self-checking bench of the configuration bank
module port_io_config_bank_tb;
   import pioc_pkg::*;
   logic clk, rst_n, ce, busCs_n, busRd_n, busWr_n;
   logic [7:0] busAddr;
   logic [15:0] busWdata, busRdata, txCoreOut, txPinIn, txPinOut, txCoreIn, got;
   logic [15:0] rxCoreOut, rxPinIn, rxPinOut, rxCoreIn, alarmStatus;
   logic rxDataEnable, rxSofOut, rxGappedClk, rxClkOut, txDataEnable, txSofOut;
   logic txGappedClk, txClkOut, rxFramerRef, txFramerRef, globalRef, txClkInActive;
   logic alarmPinFirst, alarmPinSecond, globalPortIrqEnable, portIrq;
   logic [6:0] subBlockIrq;
   pioc_ref_type refOut;
   pioc_txclk_src_type txClkSrc;
   pioc_timing_type pinTiming;
   pioc_loopback_type loopback;
   int seed = 45269;
   int bad_count = 0;
   int cmp_count = 0;
   int c3 = 0, c4 = 0, ti = 0, ri = 0;
   int addrQ[$] = '{8'h44, 8'h46, 8'h4A, 8'h4C, 8'h50, 8'h48, 8'h47};

   pioc_config_bank uut (.clk, .rst_n, .ce, .busCs_n, .busRd_n, .busWr_n, .busAddr,
      .busWdata, .busRdata, .rxDataEnable, .rxSofOut, .rxGappedClk, .rxClkOut,
      .txDataEnable, .txSofOut, .txGappedClk, .txClkOut, .txCoreOut, .txPinIn, .txPinOut,
      .txCoreIn, .rxCoreOut, .rxPinIn, .rxPinOut, .rxCoreIn, .rxFramerRef, .txFramerRef,
      .globalRef, .refOut, .txClkInActive, .txClkSrc, .pinTiming, .loopback, .alarmStatus,
      .alarmPinFirst, .alarmPinSecond, .subBlockIrq, .globalPortIrqEnable, .portIrq);
   pioc_host_model host (.clk, .busCs_n, .busRd_n, .busWr_n, .busAddr, .busWdata,
      .busRdata);

   // clock and watchdog
   initial clk = 1'b0;
   always #50 clk = ~clk;
   initial begin
      #200000;
      bad_count++;
      summarize();
   end

   // verdict and end of run
   task automatic summarize();
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // random core, pin, reference and request inputs
   task automatic drive();
      {rxDataEnable, rxSofOut, rxGappedClk, rxClkOut, txDataEnable, txSofOut, txGappedClk,
         txClkOut, rxFramerRef, txFramerRef, globalRef, txClkInActive, globalPortIrqEnable,
         subBlockIrq} = 20'($random(seed));
      {txCoreOut, txPinIn} = $random(seed);
      {rxCoreOut, rxPinIn} = $random(seed);
      alarmStatus = 16'($random(seed));
   endtask

   // register model
   task automatic modelWrite(int a, int d);
      case (a)
         8'h44: c3 = d & 16'h36FF;
         8'h46: c4 = d & 16'h07FF;
         8'h4A: ti = d & 16'h17FF;
         8'h4C: ri = d & 16'h16DE;
         default: ;
      endcase
   endtask

   function automatic logic [15:0] expRead(int a);
      case (a)
         8'h44: return 16'(c3);
         8'h46: return 16'(c4);
         8'h4A: return 16'(ti);
         8'h4C: return 16'(ri);
         8'h50: return 16'({subBlockIrq[6:1], 3'b000, subBlockIrq[0]});
         default: return 16'h0000;
      endcase
   endfunction

   // all configuration outputs against the model
   task automatic checkOuts();
      int lb;
      int src;
      logic [15:0] tm;
      logic [15:0] rm;
      logic pr;
      lb = (c4 >> 8) & 7;
      tm = txCoreOut;
      tm[12] = c3[9] ? txSofOut : txDataEnable;
      tm[1] = c3[10] ? txClkOut : txGappedClk;
      rm = rxCoreOut;
      rm[12] = c3[12] ? rxSofOut : rxDataEnable;
      rm[1] = c3[13] ? rxClkOut : rxGappedClk;
      pr = c3[6] ? txFramerRef : rxFramerRef;
      src = c3[4] ? ((!c3[3] && !txClkInActive) ? 2 : 1) :
         c3[3] ? ((lb >= 1 && lb <= 4) ? 1 : 0) : (txClkInActive ? 0 : 2);
      `CHK("txPinOut", ((tm ^ 16'(ti)) & 16'h17FF), txPinOut)
      `CHK("txCoreIn", ((txPinIn ^ 16'(ti)) & 16'h17FF), txCoreIn)
      `CHK("rxPinOut", ((rm ^ 16'(ri)) & 16'h16DE), rxPinOut)
      `CHK("rxCoreIn", ((rxPinIn ^ 16'(ri)) & 16'h16DE), rxCoreIn)
      `CHK("refOut", {pr, (c3[5] ? pr : globalRef)}, refOut)
      `CHK("txClkSrc", 2'(src), txClkSrc)
      `CHK("pinTiming", 3'(c3 & 7), pinTiming)
      `CHK("loopback", {lb == 1, lb == 2, lb == 3, lb == 4}, loopback)
      `CHK("alarmFirst", alarmStatus[c4 & 15], alarmPinFirst)
      `CHK("alarmSecond", alarmStatus[(c4 >> 4) & 15], alarmPinSecond)
      `CHK("portIrq", (|subBlockIrq & globalPortIrqEnable), portIrq)
   endtask

   // every register and two unmapped addresses read back, then outputs
   task automatic readAll();
      foreach (addrQ[k]) begin
         host.rd(8'(addrQ[k]), got);
         `CHK("readback", expRead(addrQ[k]), got)
      end
      checkOuts();
   endtask

   // one write, read back at once, outputs checked
   task automatic step(logic [7:0] a, logic [15:0] d);
      drive();
      host.wr(a, d);
      modelWrite(a, d);
      host.rd(a, got);
      `CHK("readback", expRead(a), got)
      checkOuts();
   endtask

   // main sequence
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      drive();
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      readAll();
      // every loopback code first, then random traffic
      for (int i = 0; i < 48; i++) begin
         if (i < 8) step(8'h46, {5'($random(seed)), 3'(i), 8'($random(seed))});
         else step(8'(addrQ[{$random(seed)} % addrQ.size()]), 16'($random(seed)));
      end
      // frozen clock enable drops a write
      ce = 1'b0;
      host.wr(8'h44, 16'hFFFF);
      ce = 1'b1;
      readAll();
      // second reset in mid-run
      rst_n = 1'b0;
      c3 = 0;
      c4 = 0;
      ti = 0;
      ri = 0;
      @(posedge clk);
      #1;
      rst_n = 1'b1;
      readAll();
      summarize();
   end
endmodule

`default_nettype wire
